// file: hdl/qep_top.sv
// Purpose: encoder position counter with Q1.31 angle and rate words
// Assumes: Avalon-MM slave, 32-bit data, byte addresses
// Notes:   index capture is left to software
//
// Summary of operation
// RQ1 - count every edge of both phases, direction aware
// RQ2 - 1024-pulse encoder spans 0..4095 then wraps
// RQ3 - programmable final and initial wrap values
// RQ4 - quad decode enable drives count from phases
// RQ5 - count only with clock source code 3
// RQ6 - debug behaviour code 3 keeps count running
// RQ7 - two-channel: phases only, no index hardware
// RQ8 - software captures count on index event
// RQ9 - count may be overwritten with zero
// RQ10 - angle is count times position scale
// RQ11 - electrical is pole pairs times mechanical
// RQ12 - position scale is 2^32 over counts per rev
// RQ13 - angle and rate are Q1.31 signed
// RQ14 - angle recomputed on conversion complete event
// RQ15 - rate from angle difference every 1 ms
// RQ16 - rate is difference times speed scale
// RQ17 - moving average smooths computed rate
// RQ18 - tick priority is software's concern
// RQ19 - scale pre-shifted N, product shifted N
// RQ20 - angle difference wraps in two's complement
`timescale 1ns/1ps
`default_nettype none
module qep_top #(
    parameter int unsigned CW       = 16,
    parameter int unsigned TICK_CYC = qep_pkg::SPEED_TICK_CYC
) (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_b_i,
    // avalon-mm slave
    input  wire logic [5:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // encoder and system events
    input  wire logic        phase_a_i,
    input  wire logic        phase_b_i,
    input  wire logic        conv_done_i,
    input  wire logic        debug_halt_i,
    // motor loop outputs
    output logic      [31:0] angle_word_o,
    output logic      [31:0] rate_word_o,
    output logic             rate_valid_o
);

    localparam int unsigned AL = qep_pkg::AVG_LOG2;
    localparam int unsigned AN = 1 << AL;

    // ==========================================================
    // registers
    logic [8:0]    ctrl_q;
    logic [CW-1:0] final_q;
    logic [CW-1:0] initial_q;
    logic [31:0]   pos_scale_q;
    logic [31:0]   spd_scale_q;
    logic [4:0]    spd_shift_q;
    logic [31:0]   angle_q;
    logic [31:0]   prev_angle_q;
    logic [31:0]   raw_rate_q;
    logic [31:0]   rate_q;
    logic          rate_vld_q;
    logic [31:0]   tick_cnt_q;
    logic [31:0]   hist_q [AN];
    logic [AL-1:0] hist_ptr_q;
    logic [33:0]   avg_sum_q;
    logic          ack_q;
    logic          wait_q;
    logic [31:0]   rdata_q;
    logic [CW-1:0] count_w;

    // ==========================================================
    // decodes
    function automatic logic [31:0] merge_be(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    wire         wr_w      = avs_write_i & ~ack_q;
    wire         rd_w      = avs_read_i & ~ack_q;
    wire         wr_ctrl_w = wr_w & (avs_address_i == qep_pkg::OFS_CTRL);
    wire [31:0]  ctrl_new_w = merge_be({23'h0, ctrl_q}, avs_writedata_i,
                                       avs_byteenable_i);
    wire [1:0]   clock_source_select_w    = ctrl_q[qep_pkg::CTRL_CLOCK_SOURCE_SELECT_LO +: 2];
    wire [1:0]   dbg_w     = ctrl_q[qep_pkg::CTRL_DBG_LO +: 2];
    wire         halt_ok_w = ~debug_halt_i | (dbg_w == qep_pkg::DBG_RUN);
    wire         run_w     = ctrl_q[qep_pkg::CTRL_QUAD_EN]           // see RQ4
                           & ctrl_q[qep_pkg::CTRL_FEAT_EN]
                           & (clock_source_select_w == qep_pkg::CLOCK_SOURCE_SELECT_EXT)          // see RQ5
                           & halt_ok_w;                             // see RQ6
    wire         zero_w    = wr_ctrl_w & ctrl_new_w[qep_pkg::CTRL_ZERO]; // see RQ9
    wire         tick_w    = (tick_cnt_q == TICK_CYC - 1);

    // angle: count times scale, low 32 bits give wrapping Q1.31
    wire [63:0]  ang_prod_w = {{(64-CW){1'b0}}, count_w} * {32'h0, pos_scale_q};
    wire [31:0]  diff_w     = angle_q - prev_angle_q;          // see RQ20
    wire [63:0]  spd_prod_w = $signed({{32{diff_w[31]}}, diff_w})
                            * $signed({32'h0, spd_scale_q});
    wire [63:0]  spd_shl_w  = spd_prod_w << spd_shift_q;        // see RQ19
    wire [33:0]  avg_nsum_w = avg_sum_q
                            - {{2{hist_q[hist_ptr_q][31]}}, hist_q[hist_ptr_q]}
                            + {{2{raw_rate_q[31]}}, raw_rate_q};

    // ==========================================================
    // phase decoder, phases A and B only
    qep_decoder #(
        .CW (CW)
    ) u_dec (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .phase_a_i (phase_a_i),                                 // see RQ7
        .phase_b_i (phase_b_i),
        .run_i     (run_w),
        .zero_i    (zero_w),
        .final_i   (final_q),
        .initial_i (initial_q),
        .count_o   (count_w)
    );

    // ==========================================================
    // register writes
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            ctrl_q      <= '0;
            final_q     <= qep_pkg::RST_FINAL[CW-1:0];
            initial_q   <= qep_pkg::RST_INITIAL[CW-1:0];
            pos_scale_q <= qep_pkg::RST_POS_SCALE;
            spd_scale_q <= qep_pkg::RST_SPD_SCALE;
            spd_shift_q <= qep_pkg::RST_SPD_SHIFT;
        end else if (wr_w) begin
            unique case (avs_address_i)
                qep_pkg::OFS_CTRL: begin
                    // zero request is a strobe, not stored
                    ctrl_q <= {1'b0, ctrl_new_w[7:0]};
                end
                qep_pkg::OFS_FINAL: begin
                    final_q <= CW'(merge_be(32'(final_q), avs_writedata_i,
                                            avs_byteenable_i));
                end
                qep_pkg::OFS_INITIAL: begin
                    initial_q <= CW'(merge_be(32'(initial_q),
                                              avs_writedata_i,
                                              avs_byteenable_i));
                end
                qep_pkg::OFS_POS_SCALE: begin
                    pos_scale_q <= merge_be(pos_scale_q, avs_writedata_i,
                                            avs_byteenable_i);
                end
                qep_pkg::OFS_SPD_SCALE: begin
                    spd_scale_q <= merge_be(spd_scale_q, avs_writedata_i,
                                            avs_byteenable_i);
                end
                qep_pkg::OFS_SPD_SHIFT: begin
                    if (avs_byteenable_i[0]) begin
                        spd_shift_q <= avs_writedata_i[4:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // angle on conversion event, rate on 1 ms tick
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            angle_q      <= '0;
            prev_angle_q <= '0;
            tick_cnt_q   <= '0;
            raw_rate_q   <= '0;
        end else begin
            if (conv_done_i) begin
                angle_q <= ang_prod_w[31:0];            // see RQ10 RQ11 RQ12 RQ14
            end
            tick_cnt_q <= tick_w ? '0 : tick_cnt_q + 1'b1;
            if (tick_w) begin
                prev_angle_q <= angle_q;                          // see RQ15
                raw_rate_q   <= spd_shl_w[63:32];       // see RQ16 RQ19 RQ13
            end
        end
    end

    // ==========================================================
    // moving average over the last AN raw rates
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            hist_ptr_q <= '0;
            avg_sum_q  <= '0;
            rate_q     <= '0;
            rate_vld_q <= 1'b0;
            for (int i = 0; i < AN; i++) begin
                hist_q[i] <= '0;
            end
        end else begin
            rate_vld_q <= 1'b0;
            if (tick_cnt_q == 32'h0000_0001) begin
                // one cycle after the raw rate settled
                hist_q[hist_ptr_q] <= raw_rate_q;
                hist_ptr_q         <= hist_ptr_q + 1'b1;
                avg_sum_q          <= avg_nsum_w;
                rate_q             <= avg_nsum_w[AL +: 32];       // see RQ17
                rate_vld_q         <= 1'b1;
            end
        end
    end

    // ==========================================================
    // bus answer: one wait cycle, then ack
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            ack_q   <= 1'b0;
            wait_q  <= 1'b1;
            rdata_q <= '0;
        end else begin
            ack_q  <= (avs_read_i | avs_write_i) & ~ack_q;
            // registered copy so the pin comes straight from a flop
            wait_q <= ~((avs_read_i | avs_write_i) & ~ack_q);
            if (rd_w) begin
                unique case (avs_address_i)
                    qep_pkg::OFS_CTRL:      rdata_q <= {23'h0, ctrl_q};
                    qep_pkg::OFS_FINAL:     rdata_q <= 32'(final_q);
                    qep_pkg::OFS_INITIAL:   rdata_q <= 32'(initial_q);
                    qep_pkg::OFS_COUNT:     rdata_q <= 32'(count_w);
                    qep_pkg::OFS_POS_SCALE: rdata_q <= pos_scale_q;
                    qep_pkg::OFS_SPD_SCALE: rdata_q <= spd_scale_q;
                    qep_pkg::OFS_SPD_SHIFT: rdata_q <= {27'h0, spd_shift_q};
                    qep_pkg::OFS_ANGLE:     rdata_q <= angle_q;
                    qep_pkg::OFS_RATE:      rdata_q <= rate_q;
                    qep_pkg::OFS_RATE_RAW:  rdata_q <= raw_rate_q;
                    default:                rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign avs_readdata_o    = rdata_q;
    assign avs_waitrequest_o = wait_q;
    assign angle_word_o      = angle_q;
    assign rate_word_o       = rate_q;
    assign rate_valid_o      = rate_vld_q;

endmodule
`default_nettype wire

// file: hdl/qep_pkg.sv
// Purpose: shared constants for the quadrature position and speed block
// Assumes: 25 MHz system clock, Avalon-MM register access
// Notes:   offsets are byte addresses of aligned 32-bit words
package qep_pkg;

    // ==========================================================
    // timing
    localparam int unsigned CLK_HZ          = 25000000;
    localparam int unsigned SPEED_TICK_US   = 1000;
    localparam int unsigned SPEED_TICK_CYC  =
        (CLK_HZ / 1000000) * SPEED_TICK_US;

    // ==========================================================
    // register offsets
    localparam logic [5:0] OFS_CTRL       = 6'h00;
    localparam logic [5:0] OFS_FINAL      = 6'h04;
    localparam logic [5:0] OFS_INITIAL    = 6'h08;
    localparam logic [5:0] OFS_COUNT      = 6'h0c;
    localparam logic [5:0] OFS_POS_SCALE  = 6'h10;
    localparam logic [5:0] OFS_SPD_SCALE  = 6'h14;
    localparam logic [5:0] OFS_SPD_SHIFT  = 6'h18;
    localparam logic [5:0] OFS_ANGLE      = 6'h1c;
    localparam logic [5:0] OFS_RATE       = 6'h20;
    localparam logic [5:0] OFS_RATE_RAW   = 6'h24;

    // ==========================================================
    // control register fields
    localparam int unsigned CTRL_QUAD_EN  = 0;
    localparam int unsigned CTRL_FEAT_EN  = 1;
    localparam int unsigned CTRL_CLOCK_SOURCE_SELECT_LO  = 2;
    localparam int unsigned CTRL_DBG_LO   = 4;
    localparam int unsigned CTRL_ZERO     = 8;
    localparam logic [1:0]  CLOCK_SOURCE_SELECT_NONE     = 2'h0;
    localparam logic [1:0]  CLOCK_SOURCE_SELECT_EXT      = 2'h3;
    localparam logic [1:0]  DBG_RUN       = 2'h3;

    // ==========================================================
    // reset values
    localparam logic [15:0] RST_FINAL     = 16'h0fff;
    localparam logic [15:0] RST_INITIAL   = 16'h0000;
    // 2^32 / (1024*4/3) truncated
    localparam logic [31:0] RST_POS_SCALE = 32'h00300000;
    localparam logic [31:0] RST_SPD_SCALE = 32'h00010000;
    localparam logic [4:0]  RST_SPD_SHIFT = 5'h00;
    localparam int unsigned AVG_LOG2      = 2;

endpackage

// file: hdl/qep_decoder.sv
// Purpose: quadrature edge decoder with modulo wrap position counter
// Assumes: phase inputs already synchronous to clk_sys_i
// Notes:   one count per edge of either phase, four per encoder pulse
`timescale 1ns/1ps
`default_nettype none
module qep_decoder #(
    parameter int unsigned CW = 16
) (
    // clock and reset
    input  wire logic          clk_sys_i,
    input  wire logic          rst_b_i,
    // encoder phases
    input  wire logic          phase_a_i,
    input  wire logic          phase_b_i,
    // control
    input  wire logic          run_i,
    input  wire logic          zero_i,
    input  wire logic [CW-1:0] final_i,
    input  wire logic [CW-1:0] initial_i,
    // count
    output logic      [CW-1:0] count_o
);

    logic          a_q;
    logic          b_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    wire           edge_w = (phase_a_i ^ a_q) | (phase_b_i ^ b_q);
    // up when the new A differs from the old B
    wire           up_w   = phase_a_i ^ b_q;
    wire           step_w = edge_w & ~((phase_a_i ^ a_q) & (phase_b_i ^ b_q));

    // ==========================================================
    // next count
    always_comb begin
        count_d = count_q;
        if (zero_i) begin
            count_d = '0;                              // see RQ9
        end else if (run_i && step_w) begin            // see RQ1
            if (up_w) begin
                count_d = (count_q == final_i) ? initial_i
                                               : count_q + 1'b1; // see RQ2
            end else begin
                count_d = (count_q == initial_i) ? final_i
                                                 : count_q - 1'b1; // see RQ3
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            a_q     <= 1'b0;
            b_q     <= 1'b0;
            count_q <= '0;
        end else begin
            a_q     <= phase_a_i;
            b_q     <= phase_b_i;
            count_q <= count_d;
        end
    end

    assign count_o = count_q;

endmodule
`default_nettype wire

// file: dv/qep_enc_model.sv
// Purpose: behavioural two-phase incremental encoder
// Assumes: one quarter step per step_i strobe
// Notes:   phases only, no index output
`timescale 1ns/1ps
`default_nettype none
module qep_enc_model (
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_b_i,
    // step command
    input  wire logic step_i,
    input  wire logic dir_up_i,
    // encoder phases
    output logic      phase_a_o,
    output logic      phase_b_o
);
    // =========================================================
    // quarter step state, a leads b when turning up
    logic [1:0] st_q;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            st_q <= 2'h0;
        end else if (step_i) begin
            st_q <= dir_up_i ? st_q + 2'h1 : st_q - 2'h1;
        end
    end
    assign phase_a_o = (st_q == 2'h1) || (st_q == 2'h2);
    assign phase_b_o = st_q[1];
endmodule
`default_nettype wire

// file: dv/qep_top_assertions.sv
// Purpose: port level checks of the position and rate block
// Assumes: one clock domain, sync active low reset
// Notes:   bound to qep_top from the test top
`timescale 1ns/1ps
`default_nettype none
module qep_top_assertions #(
    parameter int unsigned TICK_CYC = 50
) (
    input wire logic        clk_sys_i,
    input wire logic        rst_b_i,
    input wire logic [5:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        conv_done_i,
    input wire logic [31:0] angle_word_o,
    input wire logic [31:0] rate_word_o,
    input wire logic        rate_valid_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    // =========================================================
    // rate tick spacing counter
    logic [31:0] gap_q;
    logic        seen_q;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            gap_q  <= 32'h0;
            seen_q <= 1'b0;
        end else if (rate_valid_o) begin
            gap_q  <= 32'h0;
            seen_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 32'h1;
        end
    end
    // =========================================================
    // bus handshake
    sequence s_req;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_ack;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    property p_ack_one;
        s_req |=> s_ack;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack late");
    property p_ack_cause;
        !avs_waitrequest_o |-> $past(avs_read_i || avs_write_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    property p_unmapped;
        s_req ##0 avs_read_i && avs_address_i == 6'h3c |=>
            avs_readdata_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped");
    property p_zero_rd;
        s_req ##0 avs_read_i && avs_address_i == qep_pkg::OFS_CTRL |=>
            avs_readdata_o[8] == 1'b0;
    endproperty
    a_zero_rd: assert property (p_zero_rd) else $error("zero bit");
    // =========================================================
    // angle and rate words
    property p_angle_cause;
        $changed(angle_word_o) |-> $past(conv_done_i);
    endproperty
    a_angle_cause: assert property (p_angle_cause) else $error("angle");
    property p_rate_pulse;
        rate_valid_o |=> !rate_valid_o [*8];
    endproperty
    a_rate_pulse: assert property (p_rate_pulse) else $error("pulse");
    property p_rate_hold;
        $changed(rate_word_o) |-> rate_valid_o;
    endproperty
    a_rate_hold: assert property (p_rate_hold) else $error("rate hold");
    property p_rate_period;
        rate_valid_o && seen_q |-> gap_q == TICK_CYC - 1;
    endproperty
    a_rate_period: assert property (p_rate_period) else $error("period");
endmodule
`default_nettype wire

// file: dv/qep_top_test.sv
// Purpose: self-checking test of the position and rate block
// Assumes: 25 MHz clock, short rate tick for simulation
// Notes:   encoder model supplies the phases
`timescale 1ns/1ps
`default_nettype none
module qep_top_test;
    localparam int unsigned TICK = 50;
    logic clk_sys_i = 1'b0, rst_b_i = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [5:0] adr = 6'h0;
    logic [31:0] wd = 32'h0, rdat, q, angle, rate;
    logic wait_n, rv, pa, pb, stp = 1'b0, up = 1'b1;
    logic conv = 1'b0, halt = 1'b0;
    int miscompares = 0, check_count = 0;
    initial forever #20 clk_sys_i = ~clk_sys_i;
    qep_top #(.TICK_CYC(TICK)) u_qep_top (.clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wait_n),
        .phase_a_i(pa), .phase_b_i(pb), .conv_done_i(conv),
        .debug_halt_i(halt), .angle_word_o(angle), .rate_word_o(rate),
        .rate_valid_o(rv));
    qep_enc_model u_qep_enc_model (.clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i), .step_i(stp), .dir_up_i(up),
        .phase_a_o(pa), .phase_b_o(pb));
    // =========================================================
    // report and compare
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // =========================================================
    // bus, encoder and event tasks
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d);
        int n;
        rd  <= !w;
        wr  <= w;
        adr <= a;
        wd  <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys_i);
            if (wait_n === 1'b0) break;
        end
        q  = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_sys_i);
        if (n == 20) begin
            miscompares++;
            print_verdict();
        end
    endtask
    task automatic rchk(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk("register", e, q);
    endtask
    task automatic step(input logic u, input int k);
        repeat (k) begin
            stp <= 1'b1;
            up  <= u;
            @(posedge clk_sys_i);
            stp <= 1'b0;
            repeat (2) @(posedge clk_sys_i);
        end
    endtask
    task automatic cdone();
        conv <= 1'b1;
        @(posedge clk_sys_i);
        conv <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
    endtask
    task automatic wait_rate();
        int n;
        for (n = 0; n < 200; n++) begin
            @(posedge clk_sys_i);
            if (rv === 1'b1) break;
        end
        if (n == 200) begin
            miscompares++;
            print_verdict();
        end
    endtask
    // =========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        @(posedge clk_sys_i);
        rchk(qep_pkg::OFS_CTRL, 32'h0);
        rchk(qep_pkg::OFS_FINAL, 32'h00000fff);
        rchk(qep_pkg::OFS_INITIAL, 32'h0);
        rchk(qep_pkg::OFS_POS_SCALE, 32'h00300000);
        rchk(qep_pkg::OFS_SPD_SCALE, 32'h00010000);
        rchk(qep_pkg::OFS_SPD_SHIFT, 32'h0);
        bus(1'b1, 6'h3c, 32'h0000ffff);
        rchk(6'h3c, 32'h0);
        bus(1'b1, qep_pkg::OFS_CTRL, 32'h0000000b);
        step(1'b1, 2);
        rchk(qep_pkg::OFS_COUNT, 32'h0);
        bus(1'b1, qep_pkg::OFS_CTRL, 32'h0000000e);
        step(1'b1, 2);
        rchk(qep_pkg::OFS_COUNT, 32'h0);
        bus(1'b1, qep_pkg::OFS_CTRL, 32'h0000000f);
        step(1'b0, 1);
        rchk(qep_pkg::OFS_COUNT, 32'h00000fff);
        step(1'b1, 1);
        rchk(qep_pkg::OFS_COUNT, 32'h0);
        step(1'b1, 3);
        rchk(qep_pkg::OFS_COUNT, 32'h3);
        cdone();
        chk("angle", 32'h00900000, angle);
        rchk(qep_pkg::OFS_ANGLE, 32'h00900000);
        halt <= 1'b1;
        step(1'b1, 1);
        rchk(qep_pkg::OFS_COUNT, 32'h3);
        bus(1'b1, qep_pkg::OFS_CTRL, 32'h0000003f);
        step(1'b1, 1);
        rchk(qep_pkg::OFS_COUNT, 32'h4);
        halt <= 1'b0;
        bus(1'b1, qep_pkg::OFS_FINAL, 32'h5);
        bus(1'b1, qep_pkg::OFS_INITIAL, 32'h2);
        step(1'b1, 2);
        rchk(qep_pkg::OFS_COUNT, 32'h2);
        bus(1'b1, qep_pkg::OFS_FINAL, 32'h00000fff);
        bus(1'b1, qep_pkg::OFS_INITIAL, 32'h0);
        bus(1'b1, qep_pkg::OFS_CTRL, 32'h0000013f);
        rchk(qep_pkg::OFS_COUNT, 32'h0);
        rchk(qep_pkg::OFS_CTRL, 32'h0000003f);
        bus(1'b1, qep_pkg::OFS_POS_SCALE, 32'h00100000);
        bus(1'b1, qep_pkg::OFS_SPD_SHIFT, 32'h4);
        cdone();
        repeat (5) wait_rate();
        step(1'b0, 1);
        cdone();
        chk("angle", 32'hfff00000, angle);
        wait_rate();
        chk("rate", 32'hffffffc0, rate);
        rchk(qep_pkg::OFS_RATE_RAW, 32'hffffff00);
        rchk(qep_pkg::OFS_RATE, 32'hffffffc0);
        print_verdict();
    end
endmodule
bind qep_top qep_top_assertions #(.TICK_CYC(TICK_CYC)) u_qep_top_assertions (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .conv_done_i(conv_done_i), .angle_word_o(angle_word_o),
    .rate_word_o(rate_word_o), .rate_valid_o(rate_valid_o));
`default_nettype wire
